//--- rtl/apcc_pkg.sv
// Package for the analog PLL configuration and phase-step control block
package apcc_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses, one word each)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADR_INPUT_CONTROL   = 8'h00;
   localparam logic [7:0] ADR_MASTER_TWO      = 8'h04;
   localparam logic [7:0] ADR_CLOCK_CONTROL   = 8'h08;
   localparam logic [7:0] ADR_ENABLE          = 8'h0C;
   localparam logic [7:0] ADR_FB_INTEGER_LO   = 8'h10;
   localparam logic [7:0] ADR_FB_INTEGER_HI   = 8'h14;
   localparam logic [7:0] ADR_FB_REMAINDER    = 8'h18;
   localparam logic [7:0] ADR_FB_DENOMINATOR  = 8'h1C;
   localparam logic [7:0] ADR_FB_BINARY_POINT = 8'h20;
   localparam logic [7:0] ADR_POSTDIVIDER     = 8'h24;
   localparam logic [7:0] ADR_PHASE_STEP      = 8'h28;
   localparam logic [7:0] ADR_STATUS          = 8'h2C;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int POS_SEL         = 0;   // pll_input_select [2:0]
   localparam int POS_ALT         = 4;   // pll_alternate_input_select [6:4]
   localparam int POS_PINSW       = 7;   // pin_driven_switch_enable
   localparam int POS_SWPIN       = 0;   // switch_pin_select [1:0]
   localparam int POS_INV         = 0;   // input_invert [2:0], one per input
   localparam int POS_PRESC       = 4;   // input_prescaler [9:4], 2 bits per input
   localparam int POS_DEC_SRC     = 0;   // decrement_source_select [2:0]
   localparam int POS_INC_SRC     = 4;   // increment_source_select [6:4]
   localparam int POS_DOWN_BIT    = 8;
   localparam int POS_UP_BIT      = 9;
   localparam int POS_DIV_TWO     = 8;   // vco_divider_two [15:8]

   // ------------------------------------------------------------------
   // Reset values and widths
   // ------------------------------------------------------------------
   localparam int         FB_INT_W       = 42;  // 9 integer + up to 33 fraction
   localparam logic [7:0] RST_VCO_DIV    = 8'h06;
   localparam logic [5:0] RST_BIN_POINT  = 6'h09;
   localparam logic [5:0] BIN_POINT_MAX  = 6'h21;
   localparam logic [2:0] SRC_REG_BIT    = 3'h0;  // 1..4 pick pins 0..3
   localparam int         NUM_INPUTS     = 3;
   localparam int         NUM_PINS       = 4;

   // ------------------------------------------------------------------
   // Input-path selection codes
   // ------------------------------------------------------------------
   localparam logic [2:0] SEL_OSC        = 3'h3;  // oscillator_input, undivided
   localparam logic [1:0] MUX_CASCADE    = 2'h3;  // 11x

   typedef enum logic [1:0] {
      APCC_PATH_DIRECT  = 2'h1,
      APCC_PATH_CASCADE = 2'h2
   } apcc_path_t;

   typedef enum logic [2:0] {
      APCC_ST_OFF     = 3'h1,
      APCC_ST_ACQUIRE = 3'h2,
      APCC_ST_RUN     = 3'h4
   } apcc_state_t;

   // Wishbone request carrier
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } apcc_wb_req_t;

   // Feedback ratio handed to the analog loop
   typedef struct packed {
      logic [FB_INT_W-1:0] integer_part;
      logic [31:0]         remainder;
      logic [31:0]         denominator;
      logic [5:0]          fraction_bits;  // 33 - binary point
      logic [3:0]          integer_bits;   // 9 direct, 7 cascaded
   } apcc_ratio_t;

endpackage

//--- rtl/apcc_top.sv
// Digital control around the fractional-N analog PLL of one channel
`timescale 1ns/100ps

module apcc_top (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire apcc_pkg::apcc_wb_req_t     wb_req_i,
   output logic [31:0]                     wb_dat_o,
   output logic                            wb_ack_o,
   output logic                            wb_err_o,
   input  wire logic [apcc_pkg::NUM_PINS-1:0] gpio_i,
   input  wire logic [apcc_pkg::NUM_INPUTS-1:0] channel_clk_i,
   input  wire logic                       osc_clk_i,
   input  wire logic                       dpll_clk_i,
   input  wire logic                       loop_locked_i,
   input  wire logic                       loop_locked_second_i,
   output logic                            ref_clk_o,
   output apcc_pkg::apcc_path_t            ref_path_o,
   output logic [2:0]                      ref_source_o,
   output logic                            analog_loop_enable_o,
   output logic                            loop_restart_o,
   output apcc_pkg::apcc_ratio_t           ratio_o,
   output logic [7:0]                      vco_divider_one_o,
   output logic [7:0]                      vco_divider_two_o,
   output logic                            phase_up_o,
   output logic                            phase_down_o
);
   import apcc_pkg::*;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]          input_ctl;
      logic [1:0]          swpin;
      logic [9:0]          clk_ctl;
      logic                enable;
      logic [FB_INT_W-1:0] fb_int;
      logic [31:0]         fb_rem;
      logic [31:0]         fb_den;
      logic [5:0]          fb_bp;
      logic [15:0]         postdiv;
      logic [9:0]          step_ctl;
      apcc_state_t         state;
      logic                restart;
      logic [NUM_INPUTS-1:0][2:0] presc_cnt;
      logic [NUM_INPUTS-1:0]      presc_clk;
      logic [NUM_INPUTS-1:0]      ch_last;
      logic                ref_clk;
      logic [2:0]          ref_src;
      apcc_path_t          path;
      logic [1:0]          up_sync;
      logic [1:0]          dn_sync;
      logic                up_last;
      logic                dn_last;
      logic                up_pulse;
      logic                dn_pulse;
      logic                ack;
      logic                err;
      logic [31:0]         rdata;
   } apcc_state_s_t;

   apcc_state_s_t cur_ff;
   apcc_state_s_t nxt_ff;

   logic [2:0] active_sel;
   logic       switch_pin;
   logic       up_src;
   logic       dn_src;
   logic       wr_hit;
   logic       rd_hit;
   logic [31:0] wmask;
   logic [NUM_INPUTS-1:0] ch_in;

   function automatic logic pick_source(input logic [2:0] code, input logic regbit,
                                        input logic [NUM_PINS-1:0] pins);
      logic r;
      r = regbit;
      if (code != SRC_REG_BIT && code <= 3'(NUM_PINS)) begin
         r = pins[code[1:0] - 2'h1];
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------------
   always_comb begin
      switch_pin = gpio_i[cur_ff.swpin];
      if (cur_ff.input_ctl[POS_PINSW] && switch_pin) begin
         active_sel = cur_ff.input_ctl[POS_ALT +: 3];
      end else begin
         active_sel = cur_ff.input_ctl[POS_SEL +: 3];
      end
      up_src = pick_source(cur_ff.step_ctl[POS_INC_SRC +: 3], cur_ff.step_ctl[POS_UP_BIT], gpio_i);
      dn_src = pick_source(cur_ff.step_ctl[POS_DEC_SRC +: 3], cur_ff.step_ctl[POS_DOWN_BIT], gpio_i);
      ch_in  = channel_clk_i ^ cur_ff.clk_ctl[POS_INV +: NUM_INPUTS];
      wmask  = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
      wr_hit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !cur_ff.ack && !cur_ff.err;
      rd_hit = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !cur_ff.ack && !cur_ff.err;
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] wd;
      logic        known;
      nxt_ff = cur_ff;
      wd     = wb_req_i.dat & wmask;
      known  = 1'b1;
      nxt_ff.ack   = 1'b0;
      nxt_ff.err   = 1'b0;
      nxt_ff.rdata = 32'h0000_0000;

      // Register writes and reads
      if (wr_hit || rd_hit) begin
         if (wb_req_i.adr == ADR_INPUT_CONTROL) begin
            if (wr_hit) nxt_ff.input_ctl = wd[7:0] | (cur_ff.input_ctl & ~wmask[7:0]);
            nxt_ff.rdata = {24'h00_0000, cur_ff.input_ctl};
         end else if (wb_req_i.adr == ADR_MASTER_TWO) begin
            if (wr_hit && wb_req_i.sel[0]) nxt_ff.swpin = wd[POS_SWPIN +: 2];
            nxt_ff.rdata = {30'h0000_0000, cur_ff.swpin};
         end else if (wb_req_i.adr == ADR_CLOCK_CONTROL) begin
            if (wr_hit) nxt_ff.clk_ctl = wd[9:0] | (cur_ff.clk_ctl & ~wmask[9:0]);
            nxt_ff.rdata = {22'h00_0000, cur_ff.clk_ctl};
         end else if (wb_req_i.adr == ADR_ENABLE) begin
            if (wr_hit && wb_req_i.sel[0]) nxt_ff.enable = wd[0];
            nxt_ff.rdata = {31'h0000_0000, cur_ff.enable};
         end else if (wb_req_i.adr == ADR_FB_INTEGER_LO) begin
            if (wr_hit) nxt_ff.fb_int[31:0] = wd | (cur_ff.fb_int[31:0] & ~wmask);
            nxt_ff.rdata = cur_ff.fb_int[31:0];
         end else if (wb_req_i.adr == ADR_FB_INTEGER_HI) begin
            if (wr_hit) nxt_ff.fb_int[FB_INT_W-1:32] = wd[9:0] | (cur_ff.fb_int[FB_INT_W-1:32] & ~wmask[9:0]);
            nxt_ff.rdata = {22'h00_0000, cur_ff.fb_int[FB_INT_W-1:32]};
         end else if (wb_req_i.adr == ADR_FB_REMAINDER) begin
            if (wr_hit) nxt_ff.fb_rem = wd | (cur_ff.fb_rem & ~wmask);
            nxt_ff.rdata = cur_ff.fb_rem;
         end else if (wb_req_i.adr == ADR_FB_DENOMINATOR) begin
            if (wr_hit) nxt_ff.fb_den = wd | (cur_ff.fb_den & ~wmask);
            nxt_ff.rdata = cur_ff.fb_den;
         end else if (wb_req_i.adr == ADR_FB_BINARY_POINT) begin
            // Larger points would give a negative fraction count; clamp
            if (wr_hit && wb_req_i.sel[0]) begin
               nxt_ff.fb_bp = (wd[5:0] > BIN_POINT_MAX) ? BIN_POINT_MAX : wd[5:0];
            end
            nxt_ff.rdata = {26'h000_0000, cur_ff.fb_bp};
         end else if (wb_req_i.adr == ADR_POSTDIVIDER) begin
            if (wr_hit) nxt_ff.postdiv = wd[15:0] | (cur_ff.postdiv & ~wmask[15:0]);
            nxt_ff.rdata = {16'h0000, cur_ff.postdiv};
         end else if (wb_req_i.adr == ADR_PHASE_STEP) begin
            if (wr_hit) nxt_ff.step_ctl = wd[9:0] | (cur_ff.step_ctl & ~wmask[9:0]);
            nxt_ff.rdata = {22'h00_0000, cur_ff.step_ctl};
         end else if (wb_req_i.adr == ADR_STATUS) begin
            nxt_ff.rdata = {30'h0000_0000, loop_locked_second_i, loop_locked_i};
         end else begin
            known = 1'b0;
         end
         nxt_ff.ack = known;
         nxt_ff.err = !known;
         if (!known) nxt_ff.rdata = 32'h0000_0000;
      end

      // Enable sequencing
      nxt_ff.restart = 1'b0;
      case (cur_ff.state)
         APCC_ST_OFF: begin
            if (nxt_ff.enable) begin
               nxt_ff.state   = APCC_ST_ACQUIRE;
               nxt_ff.restart = 1'b1;
            end
         end
         APCC_ST_ACQUIRE: begin
            nxt_ff.state = nxt_ff.enable ? APCC_ST_RUN : APCC_ST_OFF;
         end
         APCC_ST_RUN: begin
            if (!nxt_ff.enable) nxt_ff.state = APCC_ST_OFF;
         end
         default: nxt_ff.state = APCC_ST_OFF;
      endcase

      // Input prescalers: toggle every 2^(n-1) input edges
      for (int i = 0; i < NUM_INPUTS; i++) begin
         logic [1:0] ps;
         ps = cur_ff.clk_ctl[POS_PRESC + 2*i +: 2];
         nxt_ff.ch_last[i] = ch_in[i];
         if (ps == 2'h0) begin
            nxt_ff.presc_clk[i] = ch_in[i];
            nxt_ff.presc_cnt[i] = 3'h0;
         end else if (ch_in[i] && !cur_ff.ch_last[i]) begin
            // Four bits so that divide-by-8 does not wrap the half count to zero
            if ({1'b0, cur_ff.presc_cnt[i]} >= (4'h1 << ps) / 4'h2 - 4'h1) begin
               nxt_ff.presc_cnt[i] = 3'h0;
               nxt_ff.presc_clk[i] = !cur_ff.presc_clk[i];
            end else begin
               nxt_ff.presc_cnt[i] = cur_ff.presc_cnt[i] + 3'h1;
            end
         end
      end

      // Reference mux
      nxt_ff.ref_src = active_sel;
      if (active_sel[2:1] == MUX_CASCADE) begin
         nxt_ff.path    = APCC_PATH_CASCADE;
         nxt_ff.ref_clk = dpll_clk_i;
      end else begin
         nxt_ff.path = APCC_PATH_DIRECT;
         if (active_sel[2]) begin
            nxt_ff.ref_clk = 1'b0;   // 10x is not a defined source
         end else if (active_sel == SEL_OSC) begin
            nxt_ff.ref_clk = osc_clk_i;
         end else begin
            nxt_ff.ref_clk = cur_ff.presc_clk[active_sel[1:0]];
         end
      end

      // Phase-step edge detection; first stage feeds only the second
      nxt_ff.up_sync  = {cur_ff.up_sync[0], up_src};
      nxt_ff.dn_sync  = {cur_ff.dn_sync[0], dn_src};
      nxt_ff.up_last  = cur_ff.up_sync[1];
      nxt_ff.dn_last  = cur_ff.dn_sync[1];
      nxt_ff.up_pulse = cur_ff.up_sync[1] ^ cur_ff.up_last;
      nxt_ff.dn_pulse = cur_ff.dn_sync[1] ^ cur_ff.dn_last;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff         <= '0;
         cur_ff.state   <= APCC_ST_OFF;
         cur_ff.path    <= APCC_PATH_DIRECT;
         cur_ff.fb_bp   <= RST_BIN_POINT;
         cur_ff.postdiv <= {RST_VCO_DIV, RST_VCO_DIV};
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   always_comb begin
      wb_ack_o             = cur_ff.ack;
      wb_err_o             = cur_ff.err;
      wb_dat_o             = cur_ff.rdata;
      ref_clk_o            = cur_ff.ref_clk;
      ref_path_o           = cur_ff.path;
      ref_source_o         = cur_ff.ref_src;
      analog_loop_enable_o = (cur_ff.state != APCC_ST_OFF);
      loop_restart_o       = cur_ff.restart;
      ratio_o.integer_part  = cur_ff.fb_int;
      ratio_o.remainder     = cur_ff.fb_rem;
      ratio_o.denominator   = cur_ff.fb_den;
      ratio_o.fraction_bits = BIN_POINT_MAX - cur_ff.fb_bp;
      ratio_o.integer_bits  = (cur_ff.path == APCC_PATH_CASCADE) ? 4'h7 : 4'h9;
      vco_divider_one_o    = cur_ff.postdiv[7:0];
      vco_divider_two_o    = cur_ff.postdiv[POS_DIV_TWO +: 8];
      // One pulse drives both post-dividers; one pulse is one eighth VCO cycle
      phase_up_o           = cur_ff.up_pulse;
      phase_down_o         = cur_ff.dn_pulse;
   end

endmodule

//--- dv/apcc_props.sv
// Port checker for the PLL control block
`timescale 1ns/100ps
module apcc_props
   import apcc_pkg::*;
(
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire apcc_wb_req_t wb_req_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic         wb_err_o,
   input wire apcc_path_t   ref_path_o,
   input wire logic [2:0]   ref_source_o,
   input wire logic         analog_loop_enable_o,
   input wire logic         loop_restart_o,
   input wire apcc_ratio_t  ratio_o,
   input wire logic         phase_up_o,
   input wire logic         phase_down_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // -----------------------------------------------------------
   // Bus handshake
   // -----------------------------------------------------------
   sequence take_s;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o && !wb_err_o;
   endsequence
   sequence reply_s;
      (wb_ack_o != wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
   endsequence
   bus_reply_a: assert property (take_s |=> reply_s) else $error("bus reply missing");
   err_data_a: assert property (wb_err_o |-> wb_dat_o == 32'h0) else $error("err with data");
   // -----------------------------------------------------------
   // Loop enable, path, ratio and phase steps
   // -----------------------------------------------------------
   restart_a: assert property ($rose(analog_loop_enable_o) |-> ##[0:2] loop_restart_o)
      else $error("no restart on enable");
   restart_once_a: assert property (loop_restart_o |=> !loop_restart_o)
      else $error("restart too long");
   run_only_a: assert property (loop_restart_o |-> analog_loop_enable_o)
      else $error("restart while off");
   cascade_path_a: assert property ($stable(ref_source_o) && ref_source_o[2:1] == MUX_CASCADE
      |-> ref_path_o == APCC_PATH_CASCADE) else $error("cascade path wrong");
   direct_path_a: assert property ($stable(ref_source_o) && !ref_source_o[2]
      |-> ref_path_o == APCC_PATH_DIRECT) else $error("direct path wrong");
   int_bits_a: assert property ($stable(ref_path_o) && ref_source_o[2:1] != 2'h2
      |-> ratio_o.integer_bits == ((ref_path_o == APCC_PATH_CASCADE) ? 4'h7 : 4'h9))
      else $error("integer bits wrong");
   frac_max_a: assert property (ratio_o.fraction_bits <= 6'h21) else $error("fraction too wide");
   up_pulse_a: assert property (phase_up_o |=> !phase_up_o) else $error("up step doubled");
   down_pulse_a: assert property (phase_down_o |=> !phase_down_o) else $error("down step doubled");
endmodule
bind apcc_top apcc_props i_apcc_props (.*);

//--- dv/apcc_far_model.sv
// Far-side model: input clocks and analog loop lock reporting
`timescale 1ns/100ps
module apcc_far_model #(
   parameter int LOCK_DELAY = 20
) (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  enable_i,
   input  wire logic  restart_i,
   output logic [2:0] chan_o,
   output logic       osc_o,
   output logic       dpll_o,
   output logic       lock_o,
   output logic       lock_two_o
);
   logic [3:0] cnt_ff;
   int         wait_ff;
   // Distinct rates for the three channels and the oscillator; dpll runs at the rate of channel 1
   assign chan_o = {cnt_ff[3], cnt_ff[2], cnt_ff[1]};
   assign osc_o  = cnt_ff[0];
   assign dpll_o = cnt_ff[2];
   always_ff @(posedge clk_i) begin
      cnt_ff <= rst_i ? 4'h0 : cnt_ff + 4'h1;
      if (rst_i || !enable_i || restart_i) begin
         wait_ff <= 0;
      end else if (wait_ff < LOCK_DELAY) begin
         wait_ff <= wait_ff + 1;
      end
   end
   // Lock only after a full settle time, never while stopped
   assign lock_o     = enable_i && (wait_ff == LOCK_DELAY);
   assign lock_two_o = lock_o;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the PLL control block
`timescale 1ns/100ps
module testbench;
   import apcc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, osc, dpll, lk, lk2, refc, en, rs, up, dn, ack, err;
   apcc_wb_req_t req = '0;
   logic [31:0] dat, q;
   logic        qe;
   logic [3:0]  gpio = 4'h0;
   logic [2:0]  chan, src;
   logic [7:0]  d1, d2;
   apcc_path_t  path;
   apcc_ratio_t ratio;
   int failures = 0, check_count = 0, cyc_cnt = 0, up_cnt = 0, dn_cnt = 0, rs_cnt = 0, n, m, b;
   always #12.5 clk_i = ~clk_i;
   apcc_far_model i_apcc_far_model (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .restart_i(rs),
      .chan_o(chan), .osc_o(osc), .dpll_o(dpll), .lock_o(lk), .lock_two_o(lk2));
   apcc_top i_apcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
      .wb_err_o(err), .gpio_i(gpio), .channel_clk_i(chan), .osc_clk_i(osc), .dpll_clk_i(dpll),
      .loop_locked_i(lk), .loop_locked_second_i(lk2), .ref_clk_o(refc), .ref_path_o(path),
      .ref_source_o(src), .analog_loop_enable_o(en), .loop_restart_o(rs), .ratio_o(ratio),
      .vco_divider_one_o(d1), .vco_divider_two_o(d2), .phase_up_o(up), .phase_down_o(dn));
   // -----------------------------------------------------------
   // Monitors and timeout
   // -----------------------------------------------------------
   always @(posedge clk_i) begin
      cyc_cnt++;
      up_cnt += (up === 1'b1);
      dn_cnt += (dn === 1'b1);
      rs_cnt += (rs === 1'b1);
      if (cyc_cnt == 20000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold until ack or err is sampled, then idle one cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      @(posedge clk_i);
      while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
      q = dat;
      qe = err;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic edges();
      logic p;
      n = 0;
      m = 0;
      p = refc;
      repeat (64) begin
         @(posedge clk_i);
         n += (refc === 1'b1 && p === 1'b0);
         m += (refc === chan[0]);
         p = refc;
      end
   endtask
   // -----------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------
   task automatic t_reset();
      check({d1, d2, en, path}, {8'h06, 8'h06, 1'b0, APCC_PATH_DIRECT});
      wb(0, ADR_POSTDIVIDER, 0);
      check(q, 32'h0606);
      wb(0, ADR_FB_BINARY_POINT, 0);
      check(q, 32'h9);
      wb(0, 8'h3C, 0);
      check({qe, q}, {1'b1, 32'h0});
      wb(1, ADR_STATUS, 32'h3);
      wb(0, ADR_STATUS, 0);
      check(q, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_mux();
      int e[8] = '{16, 8, 4, 32, 0, 0, 8, 8};
      for (int s = 0; s < 8; s++) if (s / 2 != 2) begin
         wb(1, ADR_INPUT_CONTROL, s);
         idle(2);
         check(src, s);
         check(path, (s > 5) ? APCC_PATH_CASCADE : APCC_PATH_DIRECT);
         edges();
         check(n >= e[s] - 1 && n <= e[s] + 1, 1'b1);
      end
      wb(1, ADR_INPUT_CONTROL, 0);
      for (int p = 1; p < 4; p++) begin
         wb(1, ADR_CLOCK_CONTROL, p << 4);
         edges();
         check(n >= (16 >> p) - 1 && n <= (16 >> p) + 1, 1'b1);
      end
      wb(1, ADR_CLOCK_CONTROL, 0);
      edges();
      b = m;
      wb(1, ADR_CLOCK_CONTROL, 1);
      edges();
      check(m, 64 - b);
      $display("test mux done");
   endtask
   task automatic t_switch();
      for (int k = 0; k < 4; k++) begin
         wb(1, ADR_MASTER_TWO, k);
         wb(1, ADR_INPUT_CONTROL, 8'h61);
         gpio <= 4'h1 << k;
         idle(5);
         check(src, 3'h1);
         wb(1, ADR_INPUT_CONTROL, 8'hE1);
         gpio <= ~(4'h1 << k);
         idle(5);
         check(src, 3'h1);
         gpio <= 4'h1 << k;
         idle(5);
         check(src, 3'h6);
      end
      gpio <= 4'h0;
      $display("test switch done");
   endtask
   task automatic t_enable();
      wb(1, ADR_INPUT_CONTROL, 0);
      wb(1, ADR_FB_INTEGER_LO, 32'h12345678);
      wb(1, ADR_FB_INTEGER_HI, 32'h2AB);
      wb(1, ADR_FB_REMAINDER, 32'h5);
      wb(1, ADR_FB_DENOMINATOR, 32'h7);
      wb(1, ADR_FB_BINARY_POINT, 32'h9);
      wb(1, ADR_ENABLE, 1);
      idle(2);
      check({rs_cnt[1:0], en}, {2'h1, 1'b1});
      check(ratio.integer_part, 42'h2AB12345678);
      check({ratio.remainder, ratio.denominator}, {32'h5, 32'h7});
      check({ratio.fraction_bits, ratio.integer_bits}, {6'h18, 4'h9});
      idle(30);
      wb(0, ADR_STATUS, 0);
      check(q, 32'h3);
      wb(1, ADR_FB_BINARY_POINT, 32'h28);
      wb(1, ADR_INPUT_CONTROL, 6);
      idle(2);
      check({ratio.fraction_bits, ratio.integer_bits}, {6'h0, 4'h7});
      wb(1, ADR_ENABLE, 0);
      idle(2);
      wb(0, ADR_STATUS, 0);
      check({q, en}, {32'h0, 1'b0});
      wb(1, ADR_ENABLE, 1);
      idle(2);
      check(rs_cnt, 2);
      $display("test enable done");
   endtask
   task automatic t_phase();
      wb(1, ADR_PHASE_STEP, 32'h100);
      wb(1, ADR_PHASE_STEP, 32'h200);
      wb(1, ADR_PHASE_STEP, 32'h0);
      idle(6);
      check({up_cnt, dn_cnt}, {32'd2, 32'd2});
      for (int k = 0; k < 4; k++) begin
         wb(1, ADR_PHASE_STEP, ((k + 1) << 4) | (k + 1));
         idle(6);
         gpio <= 4'h1 << k;
         idle(6);
         gpio <= 4'h0;
         idle(6);
         check({up_cnt, dn_cnt}, {2 * k + 4, 2 * k + 4});
      end
      $display("test phase done");
   endtask
   initial begin
      idle(6);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_mux();
      t_switch();
      t_enable();
      t_phase();
      end_sim();
   end
endmodule
